// ===== shared/arxf_defines.svh
// constants of the receive acceptance filter: field positions, sizes, resets
`ifndef ARXF_DEFINES_SVH
`define ARXF_DEFINES_SVH

`define ARXF_LABEL_W 8
`define ARXF_LABEL_LSB 0
`define ARXF_SDI_LSB 8
`define ARXF_SDI_W 2
`define ARXF_PARITY_BIT 31
`define ARXF_WORD_W 32
`define ARXF_LABEL_COUNT 256
`define ARXF_LABEL_FIRST 8'h00
`define ARXF_LABEL_LAST 8'hff
`define ARXF_CNT_W 16
`define ARXF_CNT_ZERO 16'h0000
`define ARXF_CNT_ONE 16'h0001
`define ARXF_BUF_DEPTH 2

`endif

// ===== shared/arxf_pkg.sv
// types shared by the receive acceptance filter and its buffer
package arxf_pkg;

  // received word, parity in the top bit, label in the low byte
  typedef struct packed {
    logic parity;
    logic [1:0] ssm;
    logic [18:0] data;
    logic [1:0] sdi;
    logic [7:0] label;
  } arxf_word_t;

  // per-channel mode flags set by software
  typedef struct packed {
    logic labelFilterEnable;
    logic parityRejectEnable;
    logic oddParitySelect;
    logic evenParitySelect;
    logic parityCheckOff;
    logic sdiFilterOn;
    logic sdiMatchHigh;
    logic sdiMatchLow;
  } arxf_mode_t;

  // one label table write
  typedef struct packed {
    logic valid;
    logic [7:0] label;
    logic accept;
    logic freshOnly;
  } arxf_tbl_wr_t;

  // which filter threw a word away
  typedef struct packed {
    logic label;
    logic fresh;
    logic parity;
    logic sdi;
  } arxf_reject_t;

  typedef enum logic {ARXF_SWEEP, ARXF_RUN} arxf_phase_t;

endpackage

// ===== core/arxf_buffer.sv
// two-entry buffer between the filter and the receive fifo
`timescale 1ns/1ns
`default_nettype none
module arxf_buffer (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic inValid,
  output var logic inReady,
  input wire arxf_pkg::arxf_word_t inWord,
  output var logic outValid,
  input wire logic outReady,
  output var arxf_pkg::arxf_word_t outWord
);

  typedef struct packed {
    logic headValid;
    arxf_pkg::arxf_word_t head;
    logic spareValid;
    arxf_pkg::arxf_word_t spare;
    logic inRdy;
  } arxf_buf_state_t;

  arxf_buf_state_t st_r;
  arxf_buf_state_t st_nxt;
  logic pop;
  logic push;

  assign pop = st_r.headValid && outReady;
  assign push = inValid && st_r.inRdy;

  always_comb begin
    st_nxt = st_r;
    if (pop) begin
      st_nxt.headValid = st_r.spareValid;
      st_nxt.head = st_r.spare;
      st_nxt.spareValid = 1'b0;
    end
    if (push) begin
      if (!st_nxt.headValid) begin
        st_nxt.headValid = 1'b1;
        st_nxt.head = inWord;
      end else begin
        st_nxt.spareValid = 1'b1;
        st_nxt.spare = inWord;
      end
    end
    st_nxt.inRdy = !st_nxt.spareValid;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.inRdy <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign inReady = st_r.inRdy;
  assign outValid = st_r.headValid;
  assign outWord = st_r.head;

  default clocking bcb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // a stalled word stays put until taken
  chk_buf_hold: assert property (outValid && !outReady |=>
    outValid && $stable(outWord))
    else $error("buffer head changed while stalled");
  cov_buf_full: cover property (outValid && !inReady);

endmodule
`default_nettype wire

// ===== core/arxf_filter.sv
// receive acceptance filter for one channel: label, fresh, parity, sdi
//
// Overview of operation
// - each channel instance filters with its own mode flags and label table
// - label filter on: keep only words whose label is marked accepted
// - fresh-only label: store word only when it differs from the last stored
// - labels are screened only while the label-filter enable flag is set
// - parity reject on: drop even-ones words if odd, odd-ones if even
// - parity check off: no word is ever dropped for parity
// - stored word keeps its received top parity bit unchanged
// - sdi filter on: keep only sdi equal to the two match flags
// - software chooses per channel to keep or drop parity errors
`timescale 1ns/1ns
`default_nettype none
`include "arxf_defines.svh"
module arxf_filter (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic rxValid,
  output var logic rxReady,
  input wire arxf_pkg::arxf_word_t rxWord,
  input wire arxf_pkg::arxf_mode_t mode,
  input wire arxf_pkg::arxf_tbl_wr_t tblWrite,
  input wire logic tblClear,
  output var logic tblBusy,
  output var logic outValid,
  input wire logic outReady,
  output var arxf_pkg::arxf_word_t outWord,
  output var arxf_pkg::arxf_reject_t rejected,
  output var logic parityError,
  output var logic [`ARXF_CNT_W-1:0] keptCount,
  output var logic [`ARXF_CNT_W-1:0] droppedCount
);

  typedef struct packed {
    arxf_pkg::arxf_phase_t phase;
    logic [`ARXF_LABEL_W-1:0] sweepIdx;
    logic tblBusy;
    logic rxReady;
    logic s1Valid;
    arxf_pkg::arxf_word_t s1Word;
    arxf_pkg::arxf_reject_t rej;
    logic parErr;
    logic [`ARXF_CNT_W-1:0] kept;
    logic [`ARXF_CNT_W-1:0] dropped;
  } arxf_filt_state_t;

  arxf_filt_state_t st_r;
  arxf_filt_state_t st_nxt;

  // label table and last stored word per label
  logic tblAccept [`ARXF_LABEL_COUNT];
  logic tblFresh [`ARXF_LABEL_COUNT];
  logic lastValid [`ARXF_LABEL_COUNT];
  arxf_pkg::arxf_word_t lastWord [`ARXF_LABEL_COUNT];

  logic take;
  logic bufReady;
  logic [`ARXF_LABEL_W-1:0] lbl;
  logic entryAccept;
  logic entryFresh;
  logic onesOdd;
  logic labelMiss;
  logic isRepeat;
  logic parityErr;
  logic parityDrop;
  logic sdiDrop;
  logic keep;

  assign take = rxValid && st_r.rxReady;
  assign lbl = rxWord.label;
  assign entryAccept = tblAccept[lbl];
  assign entryFresh = tblFresh[lbl];
  assign onesOdd = ^rxWord;

  // label screening only while enabled
  assign labelMiss = mode.labelFilterEnable && !entryAccept;
  assign isRepeat = mode.labelFilterEnable && entryAccept && entryFresh &&
    lastValid[lbl] && (lastWord[lbl] == rxWord);

  assign parityErr = !mode.parityCheckOff &&
    ((mode.oddParitySelect && !onesOdd) ||
     (mode.evenParitySelect && onesOdd));
  assign parityDrop = mode.parityRejectEnable && parityErr;

  assign sdiDrop = mode.sdiFilterOn &&
    (rxWord.sdi != {mode.sdiMatchHigh, mode.sdiMatchLow});

  assign keep = !(labelMiss || isRepeat || parityDrop || sdiDrop);

  always_comb begin
    st_nxt = st_r;
    st_nxt.rej = '0;
    st_nxt.parErr = 1'b0;
    // held word moves on when the buffer has room
    if (st_r.s1Valid && bufReady) begin
      st_nxt.s1Valid = 1'b0;
    end
    if (take) begin
      st_nxt.parErr = parityErr;
      st_nxt.rej.label = labelMiss;
      st_nxt.rej.fresh = isRepeat && !labelMiss;
      st_nxt.rej.parity = parityDrop;
      st_nxt.rej.sdi = sdiDrop;
      if (keep) begin
        st_nxt.s1Valid = 1'b1;
        // word passes through untouched, parity bit included
        st_nxt.s1Word = rxWord;
        st_nxt.kept = st_r.kept + `ARXF_CNT_ONE;
      end else begin
        st_nxt.dropped = st_r.dropped + `ARXF_CNT_ONE;
      end
    end
    unique case (st_r.phase)
      arxf_pkg::ARXF_SWEEP: begin
        if (st_r.sweepIdx == `ARXF_LABEL_LAST) begin
          st_nxt.phase = arxf_pkg::ARXF_RUN;
        end
        st_nxt.sweepIdx = st_r.sweepIdx + 8'h01;
      end
      arxf_pkg::ARXF_RUN: begin
        if (tblClear) begin
          st_nxt.phase = arxf_pkg::ARXF_SWEEP;
          st_nxt.sweepIdx = `ARXF_LABEL_FIRST;
        end
      end
    endcase
    st_nxt.tblBusy = (st_nxt.phase == arxf_pkg::ARXF_SWEEP);
    // words wait while the table is being cleared
    st_nxt.rxReady = !st_nxt.tblBusy && !st_nxt.s1Valid;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= '0;
      st_r.phase <= arxf_pkg::ARXF_SWEEP;
      st_r.sweepIdx <= `ARXF_LABEL_FIRST;
      st_r.tblBusy <= 1'b1;
      st_r.kept <= `ARXF_CNT_ZERO;
      st_r.dropped <= `ARXF_CNT_ZERO;
    end else begin
      st_r <= st_nxt;
    end
  end

  // table: cleared by sweep, loaded by software, last word on each keep
  always_ff @(posedge ref_clk) begin
    if (st_r.phase == arxf_pkg::ARXF_SWEEP) begin
      tblAccept[st_r.sweepIdx] <= 1'b0;
      tblFresh[st_r.sweepIdx] <= 1'b0;
      lastValid[st_r.sweepIdx] <= 1'b0;
    end else begin
      if (tblWrite.valid) begin
        tblAccept[tblWrite.label] <= tblWrite.accept;
        tblFresh[tblWrite.label] <= tblWrite.freshOnly;
        lastValid[tblWrite.label] <= 1'b0;
      end
      if (take && keep) begin
        lastWord[lbl] <= rxWord;
        lastValid[lbl] <= 1'b1;
      end
    end
  end

  arxf_buffer u_buffer (
    .ref_clk(ref_clk),
    .reset(reset),
    .inValid(st_r.s1Valid),
    .inReady(bufReady),
    .inWord(st_r.s1Word),
    .outValid(outValid),
    .outReady(outReady),
    .outWord(outWord)
  );

  assign rxReady = st_r.rxReady;
  assign tblBusy = st_r.tblBusy;
  assign rejected = st_r.rej;
  assign parityError = st_r.parErr;
  assign keptCount = st_r.kept;
  assign droppedCount = st_r.dropped;

  default clocking fcb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  chk_label_drop: assert property (
    take && mode.labelFilterEnable && !tblAccept[lbl] |=>
      rejected.label && !st_r.s1Valid)
    else $error("word with unlisted label was kept");

  chk_label_open: assert property (
    take && !mode.labelFilterEnable |=>
      !rejected.label && !rejected.fresh)
    else $error("label screened while filter disabled");

  chk_fresh_repeat: assert property (
    take && mode.labelFilterEnable && tblAccept[lbl] && tblFresh[lbl] &&
    lastValid[lbl] && lastWord[lbl] == rxWord |=>
      rejected.fresh && !st_r.s1Valid)
    else $error("repeated word stored on fresh-only label");

  chk_parity_drop: assert property (
    take && mode.parityRejectEnable && !mode.parityCheckOff &&
    mode.oddParitySelect && !(^rxWord) |=>
      parityError && rejected.parity && !st_r.s1Valid)
    else $error("even-ones word kept under odd parity");

  chk_parity_off: assert property (
    take && mode.parityCheckOff |=> !rejected.parity && !parityError)
    else $error("word dropped for parity while check off");

  chk_parity_choice: assert property (
    take && !mode.parityRejectEnable |=> !rejected.parity)
    else $error("parity drop without reject enabled");

  chk_word_intact: assert property (
    take && keep |=> st_r.s1Valid && st_r.s1Word == $past(rxWord) &&
      st_r.s1Word.parity == $past(rxWord[`ARXF_PARITY_BIT]))
    else $error("stored word differs from received word");

  chk_sdi_match: assert property (
    take && mode.sdiFilterOn &&
    rxWord.sdi != {mode.sdiMatchHigh, mode.sdiMatchLow} |=>
      rejected.sdi && !st_r.s1Valid)
    else $error("word with other sdi was kept");

  chk_sdi_open: assert property (
    take && !mode.sdiFilterOn |=> !rejected.sdi)
    else $error("sdi screened while filter off");

  chk_all_pass: assert property (
    take |=> st_r.s1Valid == (rejected == '0))
    else $error("store decision disagrees with filter results");

  chk_sweep_len: assert property (
    !tblBusy ##1 tblBusy |-> tblBusy [*8])
    else $error("table clear ended early");

  cov_kept_word: cover property (take && keep ##1 outValid);
  cov_fresh_drop: cover property (take && isRepeat);
  cov_sdi_three: cover property (take && mode.sdiFilterOn &&
    mode.sdiMatchHigh && mode.sdiMatchLow && keep);

endmodule
`default_nettype wire

// ===== bench/arxf_word_source.sv
// transmitting equipment model: offers received words on the handshake
`timescale 1ns/1ns
`default_nettype none
module arxf_word_source (
  input wire logic ref_clk,
  input wire logic rxReady,
  output var logic rxValid,
  output var arxf_pkg::arxf_word_t rxWord
);
  initial begin
    rxValid = 1'b0;
    rxWord = '0;
  end
  // called just after an edge; holds the word until the take edge
  task automatic send(input logic [31:0] w, input int gap);
    if (gap > 0) begin
      rxValid = 1'b0;
      rxWord = ~rxWord;
      repeat (gap) begin
        @(posedge ref_clk);
        #1;
      end
    end
    rxValid = 1'b1;
    rxWord = w;
    while (!rxReady) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    #1;
  endtask
  // released line shows the inverse of the last word
  task automatic idle();
    rxValid = 1'b0;
    rxWord = ~rxWord;
  endtask
endmodule
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench of the receive acceptance filter
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic rxValid, rxReady, tblBusy, outValid;
  logic tblClear = 1'b0;
  logic outReady = 1'b0;
  arxf_pkg::arxf_word_t rxWord, outWord;
  arxf_pkg::arxf_mode_t mode = '0;
  arxf_pkg::arxf_tbl_wr_t tblWrite = '0;
  logic [15:0] keptCount, droppedCount;
  arxf_pkg::arxf_reject_t rejected;
  logic parityError, expPar;
  logic [3:0] expRej;
  logic [31:0] lfsrState = 32'ha1d0cb36;
  logic [31:0] r, rm, w;
  logic [31:0] expQ[$];
  logic [31:0] lastW[256];
  bit acc[256], fr[256], lastV[256];
  int mismatches = 0, samples_checked = 0, nKept = 0, nDrop = 0, k;
  logic [7:0] modes[11] = '{8'h08, 8'h68, 8'h60, 8'h50, 8'h20, 8'h04,
    8'h05, 8'h06, 8'h07, 8'h88, 8'he5};

  arxf_filter dut (.ref_clk(ref_clk), .reset(reset), .rxValid(rxValid),
    .rxReady(rxReady), .rxWord(rxWord), .mode(mode), .tblWrite(tblWrite),
    .tblClear(tblClear), .tblBusy(tblBusy), .outValid(outValid),
    .outReady(outReady), .outWord(outWord), .rejected(rejected),
    .parityError(parityError), .keptCount(keptCount),
    .droppedCount(droppedCount));
  arxf_word_source src (.ref_clk(ref_clk), .rxReady(rxReady),
    .rxValid(rxValid), .rxWord(rxWord));

  always #2 ref_clk = ~ref_clk;

  function automatic logic [31:0] rnd();
    repeat (32) lfsrState = {lfsrState[30:0], ^(lfsrState & 32'h80200003)};
    return lfsrState;
  endfunction

  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic model(input logic [31:0] wd);
    arxf_pkg::arxf_word_t x;
    bit perr;
    x = wd;
    perr = !mode.parityCheckOff &&
      ((mode.oddParitySelect && !(^wd)) || (mode.evenParitySelect && ^wd));
    expPar = perr;
    expRej = 4'h0;
    expRej[3] = mode.labelFilterEnable && !acc[x.label];
    expRej[2] = mode.labelFilterEnable && acc[x.label] && fr[x.label] &&
      lastV[x.label] && lastW[x.label] == wd;
    expRej[1] = mode.parityRejectEnable && perr;
    expRej[0] = mode.sdiFilterOn &&
      x.sdi != {mode.sdiMatchHigh, mode.sdiMatchLow};
    if (expRej != 4'h0) begin
      nDrop++;
    end else begin
      nKept++;
      expQ.push_back(wd);
      lastW[x.label] = wd;
      lastV[x.label] = 1;
    end
  endtask

  task automatic wait_table();
    for (k = 0; k < 300 && tblBusy !== 1'b0; k++) begin
      @(posedge ref_clk);
      #1;
    end
    check("tblBusy", {31'h0, tblBusy}, 32'h0);
  endtask

  task automatic tbl_write(input logic [7:0] l, input bit a, input bit f);
    tblWrite = '{1'b1, l, a, f};
    @(posedge ref_clk);
    #1;
    tblWrite = '0;
    acc[l] = a;
    fr[l] = f;
    lastV[l] = 0;
    @(posedge ref_clk);
    #1;
  endtask

  always begin
    @(posedge ref_clk);
    #1;
    rm = rnd();
    outReady = rm[0] | rm[1];
    #1;
    if (outValid === 1'b1 && outReady) begin
      check("outWord", outWord,
        expQ.size() != 0 ? expQ.pop_front() : ~outWord);
    end
  end

  initial begin
    #100000;
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    wait_table();
    for (int i = 0; i < 11; i++) begin
      mode = arxf_pkg::arxf_mode_t'(modes[i]);
      if (modes[i][7]) begin
        tblClear = 1'b1;
        @(posedge ref_clk);
        #1;
        tblClear = 1'b0;
        check("tblBusy", {31'h0, tblBusy}, 32'h1);
        wait_table();
        for (int j = 0; j < 256; j++) begin
          acc[j] = 0;
          fr[j] = 0;
          lastV[j] = 0;
        end
        tbl_write(8'h04, 1, 0);
        tbl_write(8'h05, 1, 1);
      end
      for (int n = 0; n < 40; n++) begin
        r = rnd();
        w = r & (modes[i][7] ? 32'h80000307 : 32'hffffffff);
        model(w);
        src.send(w, r[31] ? 0 : int'(r[30:29]));
        check("rejected", {28'h0, rejected}, {28'h0, expRej});
        check("parityError", {31'h0, parityError}, {31'h0, expPar});
      end
      src.idle();
      for (k = 0; k < 100 && expQ.size() != 0; k++) begin
        @(posedge ref_clk);
        #1;
      end
      repeat (4) @(posedge ref_clk);
      #1;
    end
    check("keptCount", {16'h0000, keptCount}, 32'(nKept & 16'hffff));
    check("droppedCount", {16'h0000, droppedCount}, 32'(nDrop));
    check("pending", 32'(expQ.size()), 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
